//--- verilog/match_irq_pkg.sv
package match_irq_pkg;

	//////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] OFS_PIN_TRIGGER_MASK = 8'h00;
	localparam logic [7:0] OFS_MATCH_PATTERN = 8'h04;
	localparam logic [7:0] OFS_MATCH_CONTROL = 8'h08;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
	localparam logic [7:0] OFS_PORT_LEVEL = 8'h14;

	//////////////////////////////////////////////////////////////////////////
	// Control and interrupt fields
	localparam int CTRL_FLAG_BIT = 0;
	localparam int CTRL_POLARITY_BIT = 1;
	localparam int CTRL_ACTIVE_BIT = 2;
	localparam int IRQ_MATCH_BIT = 0;

	//////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0] RST_PIN_TRIGGER_MASK = 8'h00;
	localparam logic [7:0] RST_MATCH_PATTERN = 8'h00;
	localparam logic RST_POLARITY = 1'b0;
	localparam logic RST_ACTIVE = 1'b0;
	localparam logic RST_IRQ_MASK = 1'b0;

	//////////////////////////////////////////////////////////////////////////
	// Timing: condition must hold longer than this many cpu_clock cycles
	localparam int MATCH_HOLD_CYCLES = 6;
	localparam logic [2:0] MATCH_SET_COUNT = 3'(MATCH_HOLD_CYCLES + 1);

	//////////////////////////////////////////////////////////////////////////
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : match_irq_pkg

//--- verilog/match_persist.sv
`timescale 1ns/1ns
`default_nettype none
module match_persist (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Condition in, qualified level out
	input wire logic cond_i,
	output logic held_o
);

	logic [2:0] run_reg;
	logic [2:0] run_next;
	wire at_limit = (run_reg == match_irq_pkg::MATCH_SET_COUNT);

	// Consecutive-cycle counter, saturating
	assign run_next = !cond_i ? 3'h0 : (at_limit ? run_reg : run_reg + 3'h1);

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run_reg <= 3'h0;
		end else begin
			run_reg <= run_next;
		end
	end

	assign held_o = at_limit;

endmodule : match_persist
`default_nettype wire

//--- verilog/port_pattern_match_interrupt.sv
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module port_pattern_match_interrupt (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Port pins
	input wire logic [7:0] port_pins_i,
	// AXI4-Lite write address
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// AXI4-Lite read address
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// Interrupt and wake
	output logic irq_o,
	output logic wake_req_o
);

	//////////////////////////////////////////////////////////////////////////
	// Reset release
	logic rst_sync1_reg;
	logic rst_sync2_reg;
	wire rst_n = rst_sync2_reg;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_sync1_reg <= 1'b0;
			rst_sync2_reg <= 1'b0;
		end else begin
			rst_sync1_reg <= 1'b1;
			rst_sync2_reg <= rst_sync1_reg;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Port pin synchroniser
	logic [7:0] port_meta_reg;
	logic [7:0] port_sync_reg;

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			port_meta_reg <= 8'hFF;
			port_sync_reg <= 8'hFF;
		end else begin
			port_meta_reg <= port_pins_i;
			port_sync_reg <= port_meta_reg;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Register state
	logic [7:0] pin_trigger_mask_reg;
	logic [7:0] match_pattern_reg;
	logic match_polarity_select_reg;
	logic match_active_reg;
	logic match_flag_reg;
	logic irq_mask_reg;
	logic irq_reg;
	logic wake_reg;

	//////////////////////////////////////////////////////////////////////////
	// Match condition
	wire [7:0] pin_diff = (port_sync_reg ^ match_pattern_reg) & pin_trigger_mask_reg;
	wire any_pin_enabled = |pin_trigger_mask_reg;
	wire pins_differ = |pin_diff;
	wire pattern_match = match_polarity_select_reg ? pins_differ : !pins_differ;
	wire match_cond = match_active_reg && any_pin_enabled && pattern_match;
	wire match_held;

	match_persist u_persist (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n),
		.cond_i(match_cond),
		.held_o(match_held)
	);

	wire flag_set = match_held && match_active_reg;

	//////////////////////////////////////////////////////////////////////////
	// Write channel
	logic aw_full_reg;
	logic w_full_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic awready_reg;
	logic wready_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;

	wire aw_take = s_axi_awvalid_i && awready_reg;
	wire w_take = s_axi_wvalid_i && wready_reg;
	wire wr_do = aw_full_reg && w_full_reg && !bvalid_reg;
	wire aw_full_next = aw_take || (aw_full_reg && !wr_do);
	wire w_full_next = w_take || (w_full_reg && !wr_do);
	wire bvalid_next = wr_do || (bvalid_reg && !s_axi_bready_i);
	wire wr_lane0 = wr_do && w_strb_reg[0];

	wire wr_hit_mask = (aw_addr_reg == match_irq_pkg::OFS_PIN_TRIGGER_MASK);
	wire wr_hit_pattern = (aw_addr_reg == match_irq_pkg::OFS_MATCH_PATTERN);
	wire wr_hit_control = (aw_addr_reg == match_irq_pkg::OFS_MATCH_CONTROL);
	wire wr_hit_status = (aw_addr_reg == match_irq_pkg::OFS_IRQ_STATUS);
	wire wr_hit_irq_mask = (aw_addr_reg == match_irq_pkg::OFS_IRQ_MASK);
	wire wr_hit_level = (aw_addr_reg == match_irq_pkg::OFS_PORT_LEVEL);
	wire wr_mapped = wr_hit_mask || wr_hit_pattern || wr_hit_control || wr_hit_status || wr_hit_irq_mask
		|| wr_hit_level;

	wire flag_clear_ctrl = wr_lane0 && wr_hit_control && w_data_reg[match_irq_pkg::CTRL_FLAG_BIT];
	wire flag_clear_stat = wr_lane0 && wr_hit_status && w_data_reg[match_irq_pkg::IRQ_MATCH_BIT];
	wire flag_clear = flag_clear_ctrl || flag_clear_stat;
	wire flag_next = flag_set || (match_flag_reg && !flag_clear);

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= match_irq_pkg::RESP_OKAY;
		end else begin
			aw_full_reg <= aw_full_next;
			w_full_reg <= w_full_next;
			awready_reg <= !aw_full_next;
			wready_reg <= !w_full_next;
			bvalid_reg <= bvalid_next;
			if (wr_do) begin
				bresp_reg <= wr_mapped ? match_irq_pkg::RESP_OKAY : match_irq_pkg::RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (aw_take) begin
			aw_addr_reg <= s_axi_awaddr_i;
		end
		if (w_take) begin
			w_data_reg <= s_axi_wdata_i;
			w_strb_reg <= s_axi_wstrb_i;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Register updates
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pin_trigger_mask_reg <= match_irq_pkg::RST_PIN_TRIGGER_MASK;
			match_pattern_reg <= match_irq_pkg::RST_MATCH_PATTERN;
			match_polarity_select_reg <= match_irq_pkg::RST_POLARITY;
			match_active_reg <= match_irq_pkg::RST_ACTIVE;
			irq_mask_reg <= match_irq_pkg::RST_IRQ_MASK;
		end else if (wr_lane0) begin
			if (wr_hit_mask) begin
				pin_trigger_mask_reg <= w_data_reg[7:0];
			end
			if (wr_hit_pattern) begin
				match_pattern_reg <= w_data_reg[7:0];
			end
			if (wr_hit_control) begin
				match_polarity_select_reg <= w_data_reg[match_irq_pkg::CTRL_POLARITY_BIT];
				match_active_reg <= w_data_reg[match_irq_pkg::CTRL_ACTIVE_BIT];
			end
			if (wr_hit_irq_mask) begin
				irq_mask_reg <= w_data_reg[match_irq_pkg::IRQ_MATCH_BIT];
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Flag, interrupt and wake
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			match_flag_reg <= 1'b0;
			irq_reg <= 1'b0;
			wake_reg <= 1'b0;
		end else begin
			match_flag_reg <= flag_next;
			irq_reg <= match_flag_reg && irq_mask_reg;
			wake_reg <= match_flag_reg && irq_mask_reg;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Read channel
	logic arready_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;

	wire ar_take = s_axi_arvalid_i && arready_reg;
	wire rvalid_next = ar_take || (rvalid_reg && !s_axi_rready_i);

	wire rd_hit_mask = (s_axi_araddr_i == match_irq_pkg::OFS_PIN_TRIGGER_MASK);
	wire rd_hit_pattern = (s_axi_araddr_i == match_irq_pkg::OFS_MATCH_PATTERN);
	wire rd_hit_control = (s_axi_araddr_i == match_irq_pkg::OFS_MATCH_CONTROL);
	wire rd_hit_status = (s_axi_araddr_i == match_irq_pkg::OFS_IRQ_STATUS);
	wire rd_hit_irq_mask = (s_axi_araddr_i == match_irq_pkg::OFS_IRQ_MASK);
	wire rd_hit_level = (s_axi_araddr_i == match_irq_pkg::OFS_PORT_LEVEL);
	wire rd_mapped = rd_hit_mask || rd_hit_pattern || rd_hit_control || rd_hit_status || rd_hit_irq_mask
		|| rd_hit_level;

	wire [7:0] control_view = {5'h00, match_active_reg, match_polarity_select_reg, match_flag_reg};
	wire [7:0] rd_byte = ({8{rd_hit_mask}} & pin_trigger_mask_reg)
		| ({8{rd_hit_pattern}} & match_pattern_reg)
		| ({8{rd_hit_control}} & control_view)
		| ({8{rd_hit_status}} & {7'h00, match_flag_reg})
		| ({8{rd_hit_irq_mask}} & {7'h00, irq_mask_reg})
		| ({8{rd_hit_level}} & port_sync_reg);

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= match_irq_pkg::RESP_OKAY;
		end else begin
			arready_reg <= !rvalid_next;
			rvalid_reg <= rvalid_next;
			if (ar_take) begin
				rdata_reg <= {24'h000000, rd_byte};
				rresp_reg <= rd_mapped ? match_irq_pkg::RESP_OKAY : match_irq_pkg::RESP_SLVERR;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Outputs
	assign s_axi_awready_o = awready_reg;
	assign s_axi_wready_o = wready_reg;
	assign s_axi_bvalid_o = bvalid_reg;
	assign s_axi_bresp_o = bresp_reg;
	assign s_axi_arready_o = arready_reg;
	assign s_axi_rvalid_o = rvalid_reg;
	assign s_axi_rdata_o = rdata_reg;
	assign s_axi_rresp_o = rresp_reg;
	assign irq_o = irq_reg;
	assign wake_req_o = wake_reg;

	//////////////////////////////////////////////////////////////////////////
	// Checks
	logic [3:0] cond_run_reg;
	wire [7:0] seen_masked = port_sync_reg & pin_trigger_mask_reg;
	wire [7:0] want_masked = match_pattern_reg & pin_trigger_mask_reg;

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cond_run_reg <= 4'h0;
		end else if (!match_cond) begin
			cond_run_reg <= 4'h0;
		end else if (cond_run_reg != 4'hF) begin
			cond_run_reg <= cond_run_reg + 4'h1;
		end
	end

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n);

	a_flag_needs_hold: assert property ($rose(match_flag_reg) |-> $past(cond_run_reg) >= 4'h7)
		else $error("match flag rose before condition held seven cycles");
	a_flag_sets_held: assert property (match_cond [*8] |-> ##1 match_flag_reg)
		else $error("match flag not set after condition held");
	a_flag_needs_active: assert property ($rose(match_flag_reg) |-> $past(match_active_reg))
		else $error("match flag set while function inactive");
	a_flag_sticky: assert property (match_flag_reg && !flag_clear |=> match_flag_reg)
		else $error("match flag dropped without a clear");
	a_flag_clears: assert property (flag_clear && !flag_set |=> !match_flag_reg)
		else $error("match flag not cleared by write one");
	a_masked_no_cond: assert property (pin_trigger_mask_reg == 8'h00 |-> !match_cond)
		else $error("match condition with all pins masked");
	a_keypress_detect: assert property (match_active_reg && match_polarity_select_reg
		&& match_pattern_reg == 8'hFF && seen_masked != pin_trigger_mask_reg
		|-> match_cond)
		else $error("enabled low pin not detected");
	a_irq_follows: assert property (match_flag_reg && irq_mask_reg |=> irq_o)
		else $error("interrupt missing for enabled flag");
	a_irq_gated: assert property (irq_o |-> $past(match_flag_reg) && $past(irq_mask_reg))
		else $error("interrupt without enabled flag");
	a_wake_tracks: assert property (wake_req_o == irq_o)
		else $error("wake request differs from interrupt");
	a_equal_match: assert property (match_active_reg && !match_polarity_select_reg
		&& pin_trigger_mask_reg != 8'h00 && seen_masked == want_masked |-> match_cond)
		else $error("equal pattern not matched");
	a_differ_match: assert property (match_active_reg && match_polarity_select_reg
		&& seen_masked != want_masked |-> match_cond)
		else $error("differing pattern not matched");
	a_differ_only: assert property (match_cond && match_polarity_select_reg
		|-> seen_masked != want_masked)
		else $error("not-equal match without a differing enabled pin");
	a_inactive_idle: assert property (!match_active_reg |-> !match_cond)
		else $error("match condition while function inactive");
	a_irq_disabled: assert property (!irq_mask_reg |=> !irq_o)
		else $error("interrupt raised while disabled");
	a_set_after_hold: assert property (flag_set |-> cond_run_reg >= 4'h7)
		else $error("flag set before condition held seven cycles");

	//////////////////////////////////////////////////////////////////////////
	// Bus checks
	a_strobe_off: assert property (wr_do && !w_strb_reg[0] |=> $stable(pin_trigger_mask_reg)
		&& $stable(match_pattern_reg) && $stable(irq_mask_reg))
		else $error("register changed by a write without byte lane zero");
	a_bresp_stable: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write response not held");
	a_read_unmapped: assert property (ar_take && !rd_mapped |=> s_axi_rvalid_o && s_axi_rresp_o == 2'h2)
		else $error("unmapped read not refused");
	a_rdata_stable: assert property (s_axi_rvalid_o && !s_axi_rready_i
		|=> s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
		else $error("read data not held");
	a_write_answer: assert property (wr_do |=> s_axi_bvalid_o)
		else $error("write performed without response");
	a_bvalid_cause: assert property ($rose(s_axi_bvalid_o) |-> $past(wr_do))
		else $error("write response without a write");
	a_aw_busy: assert property (aw_full_reg |-> !s_axi_awready_o)
		else $error("write address accepted while one is pending");
	a_w_busy: assert property (w_full_reg |-> !s_axi_wready_o)
		else $error("write data accepted while one is pending");
	a_ar_busy: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read address accepted while data is pending");

	c_flag_rise: cover property ($rose(match_flag_reg));
	c_irq_rise: cover property ($rose(irq_o));
	c_clear_set_clash: cover property (flag_clear && flag_set);
	c_unmapped_write: cover property (wr_do && !wr_mapped);
	c_equal_flag: cover property ($rose(match_flag_reg) && !match_polarity_select_reg);

endmodule : port_pattern_match_interrupt
`default_nettype wire

//--- tb/keypad_model.sv
`timescale 1ns/1ns
`default_nettype none
module keypad_model (
	// Key and bus controls
	input wire logic [7:0] key_down_i,
	input wire logic bus_en_i,
	input wire logic [7:0] bus_val_i,
	// Port pins
	output logic [7:0] pins_o
);
	// Pulled-up keys read low when pressed; bus lines drive their value
	assign pins_o = bus_en_i ? bus_val_i : ~key_down_i;
endmodule : keypad_model
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	localparam logic [7:0] MSK = match_irq_pkg::OFS_PIN_TRIGGER_MASK;
	localparam logic [7:0] PAT = match_irq_pkg::OFS_MATCH_PATTERN;
	localparam logic [7:0] CTL = match_irq_pkg::OFS_MATCH_CONTROL;
	localparam logic [7:0] STS = match_irq_pkg::OFS_IRQ_STATUS;
	localparam logic [7:0] IEN = match_irq_pkg::OFS_IRQ_MASK;
	localparam logic [7:0] LVL = match_irq_pkg::OFS_PORT_LEVEL;
	localparam logic [7:0] RST_LIST [5] = '{MSK, PAT, CTL, STS, IEN};
	logic sys_clk, rst_n, awvalid, wvalid, bready, arvalid, rready, bus_en;
	logic awready, wready, bvalid, arready, rvalid, irq, wake;
	logic [7:0] awaddr, araddr, key_down, bus_val, pins, m, p, v;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, resp;
	logic pol, act, ie, f;
	int fail_count, n_checks, cyc;

	keypad_model u_keypad_model (.key_down_i(key_down), .bus_en_i(bus_en), .bus_val_i(bus_val), .pins_o(pins));
	port_pattern_match_interrupt u_port_pattern_match_interrupt (
		.sys_clk_i(sys_clk), .rst_n_i(rst_n), .port_pins_i(pins),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.irq_o(irq), .wake_req_o(wake));

	////////////////////////////////////////////////////////////////////////////
	// Clock and timeout
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			fail_count++;
			finish_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Helpers
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] dat);
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= dat;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
		resp = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : rd

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(d, e);
	endtask : rdc

	task automatic press(input int n);
		@(posedge sys_clk);
		key_down <= 8'h01;
		repeat (n) @(posedge sys_clk);
		key_down <= 8'h00;
		repeat (15) @(posedge sys_clk);
	endtask : press

	// Expected flag from mask, pattern, port level, polarity and active bit
	function automatic logic exp_flag(input logic [7:0] msk, input logic [7:0] pat, input logic [7:0] lvl,
		input logic p_sel, input logic on);
		return on && (msk != 8'h00) && (((lvl & msk) != (pat & msk)) == p_sel);
	endfunction : exp_flag

	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{rst_n, awvalid, wvalid, bready, arvalid, rready, bus_en} = '0;
		{awaddr, araddr, key_down, bus_val, wdata} = '0;
		wstrb = 4'hF;
		d = $urandom(44);
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		// Reset values and unmapped address
		for (int i = 0; i < 5; i++)
			rdc(RST_LIST[i], 32'h0);
		chk(resp, match_irq_pkg::RESP_OKAY);
		rdc(LVL, 32'hFF);
		rdc(8'h40, 32'h0);
		chk(resp, match_irq_pkg::RESP_SLVERR);
		wr(8'h40, 32'hFF);
		chk(resp, match_irq_pkg::RESP_SLVERR);
		wstrb <= 4'hE;
		wr(PAT, 32'hFF);
		chk(resp, match_irq_pkg::RESP_OKAY);
		wstrb <= 4'hF;
		rdc(PAT, 32'h0);
		$display("test reset done");

		// Key press with pattern all ones, not-equal
		wr(MSK, 32'hFF);
		wr(PAT, 32'hFF);
		wr(IEN, 32'h1);
		wr(CTL, 32'h6);
		press(6);
		rdc(CTL, 32'h6);
		chk(irq, 1'b0);
		press(7);
		rdc(CTL, 32'h7);
		chk(irq, 1'b1);
		chk(wake, 1'b1);
		repeat (20) @(posedge sys_clk);
		rdc(STS, 32'h1);
		wr(CTL, 32'h7);
		rdc(CTL, 32'h6);
		chk(irq, 1'b0);
		press(10);
		wr(STS, 32'h1);
		rdc(CTL, 32'h6);
		wr(MSK, 32'hFE);
		press(10);
		rdc(CTL, 32'h6);
		$display("test keypress done");

		// Random masks, patterns, polarities and port values
		bus_en <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			m = (i == 0) ? 8'h00 : 8'($urandom);
			p = 8'($urandom);
			v = (i % 3 == 1) ? (p ^ ~m) : 8'($urandom);
			{pol, act, ie} = 3'($urandom);
			bus_val <= v;
			wr(CTL, 32'h0);
			wr(CTL, 32'h1);
			wr(MSK, {24'h0, m});
			wr(PAT, {24'h0, p});
			wr(IEN, {31'h0, ie});
			wr(CTL, {29'h0, act, pol, 1'b0});
			repeat (15) @(posedge sys_clk);
			f = exp_flag(m, p, v, pol, act);
			rdc(CTL, {29'h0, act, pol, f});
			chk(irq, f && ie);
			chk(wake, f && ie);
			rdc(STS, {31'h0, f});
			rdc(LVL, {24'h0, v});
		end
		$display("test random done");
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
